// ===== dv/apec_capture_monitor.sv
`timescale 1ns/1ns
`default_nettype none
module apec_capture_monitor
  import apec_pkg::*;
#(parameter int CHANNELS = APEC_CHANNELS) (
  input wire logic                clock,
  input wire logic                rst_n,
  input wire logic [CHANNELS-1:0] thresholdHit,
  input wire logic                converterReady,
  input wire logic [8:0]          converterResult,
  input wire logic                readoutStrobe,
  input wire logic                pulseGateEnable,
  input wire logic                converterReset,
  input wire logic [CHANNELS-1:0] captureFlags,
  input wire logic [8:0]          particle_count_channel,
  input wire logic                telemetryValid
);
  default clocking @(posedge clock); endclocking
  default disable iff (!rst_n);
  // ----
  // checks
  // ----
  lowest_take_a: assert property (captureFlags == 0 && !pulseGateEnable && !converterReset
    && $past(captureFlags) == 0 && !$past(converterReset) && |thresholdHit |=> pulseGateEnable
    && captureFlags == ($past(thresholdHit) & (~$past(thresholdHit) + 1'b1))) else $error("bad capture");
  one_hot_a: assert property ($onehot0(captureFlags)) else $error("flags not one-hot");
  flags_hold_a: assert property (captureFlags != 0 |=> captureFlags == 0
    || $stable(captureFlags)) else $error("flags changed");
  gate_cause_a: assert property (pulseGateEnable |-> captureFlags != 0) else $error("gate w/o flag");
  gate_close_a: assert property (pulseGateEnable && !converterReady |=> !pulseGateEnable)
    else $error("gate open");
  reject_clear_a: assert property ($rose(converterReady) && captureFlags != 0
    && !converterResult[8] |-> ##[1:2] captureFlags == 0) else $error("no reject");
  valid_move_a: assert property (readoutStrobe && converterReady && $past(converterReady)
    && $past(converterReady, 2) && !pulseGateEnable && captureFlags != 0 && converterResult[8]
    |=> telemetryValid && converterReset && captureFlags == 0
    && particle_count_channel == $past(converterResult)) else $error("no transfer");
  busy_skip_a: assert property (readoutStrobe && !converterReady |=> !telemetryValid
    && $stable(particle_count_channel)) else $error("busy transfer");
endmodule : apec_capture_monitor
bind apec_capture apec_capture_monitor #(.CHANNELS(CHANNELS)) mon_u (.*);
`default_nettype wire

// ===== dv/apec_telemetry_model.sv
`timescale 1ns/1ns
`default_nettype none
// ----
// readout strobe source, short period
// ----
module apec_telemetry_model (
  input  wire logic clock,
  input  wire logic rst_n,
  output logic      readoutStrobe
);
  logic [5:0] tick;
  always_ff @(posedge clock) begin
    if (!rst_n) tick <= 6'h00;
    else tick <= (tick == 6'h27) ? 6'h00 : tick + 6'h01;
  end
  // one-cycle pulse each period
  assign readoutStrobe = rst_n && tick == 6'h27;
endmodule : apec_telemetry_model
`default_nettype wire

// ===== dv/tb.sv
`timescale 1ns/1ns
`default_nettype none
module tb;
  import apec_pkg::*;
  logic clock = 0, rst_n = 0, converterReady = 1, readoutStrobe, pulseGateEnable, converterReset;
  logic telemetryValid;
  logic [9:0] thresholdHit = 0, captureFlags;
  logic [8:0] converterResult = 0, particle_count_channel, expCnt;
  logic [3:0] detector_index_channel;
  logic [11:0] countRate;
  logic [15:0] r = 16'h005B;
  int n_errors = 0, n_compared = 0, k;
  always #10 clock = ~clock;
  apec_capture dut_u (.*);
  apec_telemetry_model tm_u (.*);
  function automatic logic [15:0] lfsr(input logic [15:0] v);
    return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
  endfunction : lfsr
  function automatic logic [3:0] low_idx(input logic [9:0] m);
    for (int i = 0; i < 10; i++) if (m[i]) return 4'(i);
    return APEC_NO_INDEX;
  endfunction : low_idx
  task automatic chk(input logic ok, input string msg);
    n_compared++;
    if (ok !== 1'b1) begin
      n_errors++;
      $display("CHECK FAILED %0t %s", $time, msg);
    end
  endtask : chk
  task automatic report_and_stop;
    $display("errors %0d compared %0d", n_errors, n_compared);
    if (n_errors == 0 && n_compared > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : report_and_stop
  // ----
  // one event through the converter
  // ----
  task automatic run_event(input logic [9:0] m, input logic [8:0] v);
    @(posedge clock) thresholdHit <= m;
    for (k = 0; k < 60 && pulseGateEnable !== 1'b1; k++) @(negedge clock);
    chk(captureFlags === 10'(1) << low_idx(m), "capture");
    @(posedge clock) thresholdHit <= 10'h000;
    repeat (2) @(posedge clock);
    converterReady <= 1'b0;
    repeat (r[2:0] + 2) @(posedge clock);
    converterResult <= v;
    converterReady <= 1'b1;
    @(negedge clock);
    chk(pulseGateEnable === 1'b0, "gate closed");
    for (k = 0; k < 200 && captureFlags !== 10'h000; k++) @(negedge clock);
    if (v[8]) expCnt = v;
    chk(particle_count_channel === expCnt, "count");
    if (v[8]) chk(detector_index_channel === low_idx(m) && telemetryValid === 1'b1, "index");
    // strobe period is shorter than one decay step, so every sample reads full scale
    chk(countRate === APEC_RATE_FULL, "rate");
    repeat (6) @(posedge clock);
  endtask : run_event
  initial begin
    #400000;
    n_errors++;
    report_and_stop;
  end
  initial begin
    expCnt = APEC_NO_RESULT;
    repeat (3) @(posedge clock);
    rst_n <= 1'b1;
    @(negedge clock);
    chk(detector_index_channel === APEC_NO_INDEX && particle_count_channel === 9'h000, "reset");
    run_event(10'h3FF, 9'h1FF);
    run_event(10'h200, 9'h0FF);
    run_event(10'h200, 9'h100);
    for (int i = 0; i < 20; i++) begin
      r = lfsr(lfsr(r));
      run_event((r[9:0] == 0) ? 10'h001 : r[9:0], r[15:7]);
    end
    report_and_stop;
  end
endmodule : tb
`default_nettype wire

// ===== hdl/apec_capture.sv
`timescale 1ns/1ns
`default_nettype none
module apec_capture
  import apec_pkg::*;
#(
  parameter int CHANNELS = APEC_CHANNELS
) (
  input  wire logic                     clock,
  input  wire logic                     rst_n,
  input  wire logic [CHANNELS-1:0]      thresholdHit,
  input  wire logic                     converterReady,
  input  wire logic [APEC_RESULT_W-1:0] converterResult,
  input  wire logic                     readoutStrobe,
  output logic                          pulseGateEnable,
  output logic                          converterReset,
  output logic [CHANNELS-1:0]           captureFlags,
  output logic [APEC_RESULT_W-1:0]      particle_count_channel,
  output logic [APEC_INDEX_W-1:0]       detector_index_channel,
  output logic [APEC_RATE_W-1:0]        countRate,
  output logic                          telemetryValid
);
  // -------------------------------------------------------------
  // state record
  // -------------------------------------------------------------
  typedef struct packed {
    apec_state_type            state;
    logic [CHANNELS-1:0]       capture;
    logic                      gate;
    logic                      readyLast;
    logic [APEC_RESULT_W-1:0]  heldResult;
    logic [APEC_INDEX_W-1:0]   heldIndex;
    logic [APEC_RESULT_W-1:0]  outResult;
    logic [APEC_INDEX_W-1:0]   outIndex;
    logic                      outValid;
    logic                      convReset;
    logic [APEC_RATE_W-1:0]    rate;
    logic                      rateFrozen;
    logic [7:0]                decayCount;
    logic [APEC_RATE_W-1:0]    rateOut;
  } apec_regs_type;

  apec_regs_type r;
  apec_regs_type next_r;

  // -------------------------------------------------------------
  // priority pick and index encode
  // -------------------------------------------------------------
  logic [CHANNELS-1:0]     pick;
  logic [CHANNELS-1:0]     lower;
  logic [APEC_INDEX_W-1:0] pickIndex;

  genvar g;
  generate
    for (g = 0; g < CHANNELS; g++) begin : gPick
      if (g == 0) begin : gFirst
        assign lower[g] = 1'b0;
      end else begin : gRest
        assign lower[g] = lower[g-1] | thresholdHit[g-1];
      end
      assign pick[g] = thresholdHit[g] & ~lower[g]; // [R15]
    end
  endgenerate

  always_comb begin
    pickIndex = APEC_NO_INDEX;
    for (int i = CHANNELS - 1; i >= 0; i--) begin
      if (pick[i]) begin
        pickIndex = APEC_INDEX_W'(i); // [R14]
      end
    end
  end

  // -------------------------------------------------------------
  // next state
  // -------------------------------------------------------------
  always_comb begin
    next_r = r;
    next_r.readyLast = converterReady;
    next_r.convReset = 1'b0;

    // indicator decays unless frozen by a valid result
    if (!r.rateFrozen) begin
      if (r.decayCount == APEC_DECAY_PERIOD) begin
        next_r.decayCount = 8'h00;
        next_r.rate = r.rate - (r.rate >> APEC_DECAY_SH) - APEC_RATE_W'(r.rate != APEC_RATE_ZERO); // [R11]
      end else begin
        next_r.decayCount = r.decayCount + 8'h01;
      end
    end

    case (r.state)
      APEC_IDLE: begin
        // inputs blocked outside idle so only one pulse enters
        if (|thresholdHit) begin
          next_r.capture = pick; // [R1] [R15]
          next_r.heldIndex = pickIndex;
          next_r.gate = 1'b1; // [R2]
          next_r.state = APEC_GATE;
        end
      end
      APEC_GATE: begin
        if (!converterReady) begin
          next_r.gate = 1'b0; // [R4]
          next_r.state = APEC_CONV;
        end
      end
      APEC_CONV: begin
        if (converterReady && !r.readyLast) begin
          if (converterResult[APEC_RESULT_W-1]) begin // [R5] [R10]
            next_r.heldResult = converterResult;
            next_r.rateFrozen = 1'b1; // [R12]
            next_r.state = APEC_HOLD;
          end else begin
            next_r.capture = '0; // [R6]
            next_r.heldIndex = APEC_NO_INDEX;
            next_r.heldResult = APEC_NO_RESULT;
            next_r.convReset = 1'b1;
            next_r.state = APEC_IDLE;
          end
        end
      end
      APEC_HOLD: begin
        // ready low means busy: the held event waits for a later strobe
        if (readoutStrobe && converterReady) begin // [R9]
          next_r.outResult = r.heldResult; // [R7]
          next_r.outIndex = r.heldIndex;
          next_r.outValid = 1'b1;
          next_r.capture = '0; // [R8]
          next_r.heldResult = APEC_NO_RESULT;
          next_r.heldIndex = APEC_NO_INDEX;
          next_r.convReset = 1'b1;
          next_r.state = APEC_IDLE;
        end
      end
      default: begin
        next_r.state = APEC_IDLE;
        next_r.gate = 1'b0;
      end
    endcase

    // every strobe samples the indicator and starts a new period
    if (readoutStrobe) begin
      next_r.rateOut = r.rate; // [R12]
      next_r.rate = APEC_RATE_FULL; // [R11]
      next_r.rateFrozen = 1'b0;
      next_r.decayCount = 8'h00;
      if (!(r.state == APEC_HOLD && converterReady)) begin
        next_r.outValid = 1'b0;
      end
    end
  end

  // -------------------------------------------------------------
  // registers
  // -------------------------------------------------------------
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      r.state      <= APEC_IDLE;
      r.capture    <= '0;
      r.gate       <= 1'b0;
      r.readyLast  <= 1'b1;
      r.heldResult <= APEC_NO_RESULT;
      r.heldIndex  <= APEC_NO_INDEX;
      r.outResult  <= APEC_NO_RESULT;
      r.outIndex   <= APEC_NO_INDEX;
      r.outValid   <= 1'b0;
      r.convReset  <= 1'b0;
      r.rate       <= APEC_RATE_FULL;
      r.rateFrozen <= 1'b0;
      r.decayCount <= 8'h00;
      r.rateOut    <= APEC_RATE_ZERO;
    end else begin
      r <= next_r;
    end
  end

  assign pulseGateEnable        = r.gate; // [R3]
  assign converterReset         = r.convReset;
  assign captureFlags           = r.capture;
  assign particle_count_channel = r.outResult; // [R14]
  assign detector_index_channel = r.outIndex;
  assign countRate              = r.rateOut;
  assign telemetryValid         = r.outValid;
endmodule : apec_capture
`default_nettype wire

// ===== hdl/apec_pkg.sv
// Function
// R1: A firing threshold comparator sets the capture flip-flop of its own channel.
// R2: Once any capture flip-flop is set, all capture inputs are blocked and the gate-control flip-flop is set.
// R3: The shaped pulse reaches the converter only while the gate-control flip-flop is set.
// R4: The gate stays open until the converter drives its ready line low, then the gate-control flip-flop clears.
// R5: When ready returns high after conversion, the top bit of the result decides validity.
// R6: A result with top bit zero clears the capture and converter outputs to the no-signal state.
// R7: A result with top bit one is held until the next readout strobe and then copied to the telemetry register.
// R8: After a transfer the converter and capture input logic are reset for the next pulse.
// R9: A readout strobe seen while the converter is busy skips the transfer and keeps the held values.
// R10: The converter resolves each gated pulse into one of 512 channels, a nine-bit result.
// R11: Each telemetry period restarts the count-rate indicator at full scale, after which it decays.
// R12: A top-bit-set result freezes the count-rate indicator until the readout strobe samples it.
// R13: The telemetry side samples count and detector index ten times per second and housekeeping once per second.
// R14: The telemetry output carries the nine-bit result and the encoded index of the set capture flip-flop.
// R15: Simultaneous comparator firings capture only one channel by fixed priority, lowest index first.
package apec_pkg;
  // -------------------------------------------------------------
  // sizes and reset values
  // -------------------------------------------------------------
  localparam int          APEC_CHANNELS   = 10;
  localparam int          APEC_RESULT_W   = 9;
  localparam int          APEC_INDEX_W    = 4;
  localparam int          APEC_RATE_W     = 12;
  localparam int          APEC_DECAY_SH   = 8;
  localparam logic [3:0]  APEC_NO_INDEX   = 4'hF;
  localparam logic [8:0]  APEC_NO_RESULT  = 9'h000;
  localparam logic [11:0] APEC_RATE_FULL  = 12'hFFF;
  localparam logic [11:0] APEC_RATE_ZERO  = 12'h000;
  localparam logic [7:0]  APEC_DECAY_PERIOD = 8'hFF;

  // -------------------------------------------------------------
  // event sequence states
  // -------------------------------------------------------------
  typedef enum logic [3:0] {
    APEC_IDLE  = 4'h1,
    APEC_GATE  = 4'h2,
    APEC_CONV  = 4'h4,
    APEC_HOLD  = 4'h8
  } apec_state_type;
endpackage : apec_pkg
